// [hw/tle_pkg.sv]
// shared constants for the tap and link event logic
// assumes a 20 MHz core clock and a byte-wide register port supplied by the serial front end
package tle_pkg;
   // register offsets
   localparam logic [7:0] ADDR_TAP_THRESHOLD  = 8'h1d;
   localparam logic [7:0] ADDR_TAP_MAX_TIME   = 8'h21;
   localparam logic [7:0] ADDR_TAP_GAP_TIME   = 8'h22;
   localparam logic [7:0] ADDR_SECOND_WINDOW  = 8'h23;
   localparam logic [7:0] ADDR_TAP_AXIS       = 8'h2a;
   localparam logic [7:0] ADDR_MOTION_SOURCE  = 8'h2b;
   localparam logic [7:0] ADDR_IRQ_MASK       = 8'h2e;
   localparam logic [7:0] ADDR_IRQ_MAP        = 8'h2f;
   localparam logic [7:0] ADDR_IRQ_FLAGS      = 8'h30;
   // reset values
   localparam logic [7:0] RST_ZERO            = 8'h00;
   // tap axis register fields
   localparam int TAX_Z        = 0;
   localparam int TAX_Y        = 1;
   localparam int TAX_X        = 2;
   localparam int TAX_VETO     = 3;
   // motion source fields (tap part; activity axis bits are outside this block)
   localparam int MSS_TAP_Z    = 0;
   localparam int MSS_TAP_Y    = 1;
   localparam int MSS_TAP_X    = 2;
   localparam int MSS_DOZING   = 3;
   // irq flag / mask / map bit positions
   localparam int IRQ_OVERRUN  = 0;
   localparam int IRQ_WMARK    = 1;
   localparam int IRQ_FFALL    = 2;
   localparam int IRQ_INACT    = 3;
   localparam int IRQ_ACT      = 4;
   localparam int IRQ_DTAP     = 5;
   localparam int IRQ_STAP     = 6;
   localparam int IRQ_DREADY   = 7;
   // one tick of the tap timers, 625 us, counted at the core clock
   localparam int TAP_TICK_US  = 625;
   localparam int CLK_MHZ      = 20;
   localparam int TAP_TICK_CYC = TAP_TICK_US * CLK_MHZ;
   localparam logic [15:0] TAP_TICK_LAST = 16'(TAP_TICK_CYC - 1);
endpackage

// [hw/tle_tap_fsm.sv]
// tap detector state machine: single and double tap qualification
// assumes a one-cycle sample strobe and a one-cycle timer tick from its parent
`timescale 1ns/1ns
module tle_tap_fsm (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       tick,
   input  wire logic       sample_stb,
   input  wire logic       above,
   input  wire logic [7:0] max_time,
   input  wire logic [7:0] gap_time,
   input  wire logic [7:0] win_time,
   input  wire logic       veto_en,
   input  wire logic       stap_en,
   input  wire logic       dtap_en,
   output logic            first_start,
   output logic            stap_pulse,
   output logic            dtap_pulse
);
   typedef enum logic [2:0] {
      TLE_IDLE  = 3'b000,
      TLE_TAP1  = 3'b001,
      TLE_GAP   = 3'b010,
      TLE_WIN   = 3'b011,
      TLE_TAP2  = 3'b100,
      TLE_WAITB = 3'b101
   } tle_tap_state_t;

   tle_tap_state_t state;
   tle_tap_state_t next_state;
   logic [8:0]     cnt;
   logic [8:0]     next_cnt;
   logic           next_stap;
   logic           next_dtap;
   logic           dbl_ok;

   // double tap needs nonzero gap and window, see R12
   assign dbl_ok = dtap_en && (gap_time != 8'h00) && (win_time != 8'h00);

   ////////////////////////////////////////////////////////////////////////
   // next state; timers advance on ticks in units of the sample clock, see R25
   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_stap   = 1'b0;
      next_dtap   = 1'b0;
      first_start = 1'b0;
      if (tick && state != TLE_IDLE)
         next_cnt = cnt + 9'h001;
      case (state)
         TLE_IDLE: begin
            if (sample_stb && above && (stap_en || dbl_ok)) begin // see R1
               next_state  = TLE_TAP1;
               next_cnt    = 9'h000;
               first_start = 1'b1;
            end
         end
         TLE_TAP1: begin
            if (cnt > {1'b0, max_time}) begin
               next_state = TLE_WAITB; // too long, see R2
            end else if (sample_stb && !above) begin
               if (dbl_ok) begin
                  next_state = TLE_GAP; // single held until double decided, see R6
                  next_cnt   = 9'h000;
               end else begin
                  next_state = TLE_IDLE;
                  next_stap  = stap_en; // see R5
               end
            end
         end
         TLE_GAP: begin
            if (veto_en && sample_stb && above) begin
               next_state = TLE_IDLE; // see R7 and R24
               next_stap  = stap_en;
            end else if (cnt >= {1'b0, gap_time} && sample_stb) begin // see R3
               if (above) begin
                  next_state = TLE_WAITB; // already high at window open, see R8
                  next_stap  = stap_en;
               end else begin
                  next_state = TLE_WIN;
                  next_cnt   = 9'h000;
               end
            end
         end
         TLE_WIN: begin
            if (sample_stb && above) begin
               next_state = TLE_TAP2; // may outlast the window, see R4
               next_cnt   = 9'h000;
            end else if (cnt >= {1'b0, win_time}) begin
               next_state = TLE_IDLE;
               next_stap  = stap_en;
            end
         end
         TLE_TAP2: begin
            if (cnt > {1'b0, max_time}) begin
               next_state = TLE_WAITB; // see R9
               next_stap  = stap_en;
            end else if (sample_stb && !above) begin
               next_state = TLE_IDLE; // see R24
               next_stap  = stap_en;
               next_dtap  = 1'b1;
            end
         end
         TLE_WAITB: begin
            // a rejected tap must drop first so it is not counted again
            if (sample_stb && !above)
               next_state = TLE_IDLE; // see R24
         end
         default: next_state = TLE_IDLE;
      endcase
   end

   // state and counter
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= TLE_IDLE;
         cnt   <= 9'h000;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // event pulses, registered
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stap_pulse <= 1'b0;
         dtap_pulse <= 1'b0;
      end else begin
         stap_pulse <= next_stap;
         dtap_pulse <= next_dtap;
      end
   end
endmodule

// [hw/tle_top.sv]
// tap, link and sleep event logic with its register slice
// assumes the serial front end presents byte writes and reads as one-cycle strobes,
// and that raw (unfiltered) samples arrive with a one-cycle strobe
`timescale 1ns/1ns
// Overview of operation
// R1 - a tap starts when any enabled axis magnitude reaches the tap threshold
// R2 - a tap lasting longer than the max-time register is not a tap
// R3 - second-tap window opens after gap time counted from first tap end
// R4 - a second tap must start inside the window but may end later
// R5 - single tap only: event when acceleration drops below threshold in time
// R6 - with double enabled, single tap event waits for double decision
// R7 - with veto bit set, any threshold hit during gap rejects double tap
// R8 - above threshold when window opens rejects the double tap
// R9 - second tap exceeding max time rejects double at that moment
// R10 - mask bits enable single and double tap detection separately
// R11 - each axis joins tap detection only when its select bit is set
// R12 - double tap runs only with nonzero gap and window values
// R13 - host should start with gap and window above 0x10, threshold above 3 g
// R14 - first axis over threshold is recorded per tap, overwritten, never cleared
// R15 - slower data rates come from decimating one common sample rate
// R16 - motion detection uses raw unfiltered samples
// R17 - with chaining set, activity is sought only after inactivity; the logic seeks activity first once chaining is set, then alternates
// R18 - flags read clears activity; no autosleep while activity flag pending
// R19 - dozing flag in motion source status shows sleep state
// R20 - sample-available event suppressed while asleep
// R21 - host may use reduced-current mode with FIFO collection for low power
// R22 - reading the flag register clears tap, activity, inactivity, free-fall
// R23 - map bit 0 routes event to pin a, 1 to pin b, ORed
// R24 - tap detector returns to idle after any double decision
// R25 - tap timers count in fixed sample-clock periods scaled by registers
module tle_top (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // raw samples, signed
   input  wire logic        sample_stb,
   input  wire logic [12:0] raw_x,
   input  wire logic [12:0] raw_y,
   input  wire logic [12:0] raw_z,
   input  wire logic [3:0]  rate_sel,
   // events from the activity, free-fall and data paths
   input  wire logic        act_evt,
   input  wire logic        inact_evt,
   input  wire logic        ffall_evt,
   input  wire logic        dready_set,
   input  wire logic        dready_clr,
   input  wire logic        wmark_lvl,
   input  wire logic        ovr_lvl,
   input  wire logic        chain_en,
   input  wire logic        autosleep_en,
   // outputs
   output logic             odr_stb,
   output logic             asleep,
   output logic             irq_pin_a,
   output logic             irq_pin_b
);
   logic [7:0]  tap_threshold;
   logic [7:0]  tap_max_time;
   logic [7:0]  tap_gap_time;
   logic [7:0]  second_tap_window;
   logic [7:0]  tap_axis_select;
   logic [7:0]  irq_mask;
   logic [7:0]  irq_map;
   logic [7:0]  irq_flags;
   logic [2:0]  tap_axis_src;
   logic [15:0] tick_cnt;
   logic        tick;
   logic [8:0]  dec_cnt;
   logic        seek_act;
   logic        first_start;
   logic        stap_pulse;
   logic        dtap_pulse;
   logic [2:0]  over;
   logic        above;
   logic        flags_read;
   logic        act_ok;
   logic        inact_ok;
   logic [7:0]  set_vec;
   logic [7:0]  live;

   // magnitude of a signed sample, upper bits compared with the 8-bit threshold
   function automatic logic [12:0] tle_mag(input logic [12:0] s);
      logic [12:0] n;
      n = s[12] ? (~s + 13'h0001) : s;
      return n;
   endfunction

   // one 62.5 mg threshold step equals 32 counts of a 1.953125 mg sample
   function automatic logic tle_over(input logic [12:0] s, input logic [7:0] th);
      logic [12:0] m;
      m = tle_mag(s);
      return (th != 8'h00) && (m[12:5] >= th);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // threshold compare on raw data, gated by the axis selects
   always_comb begin
      over[2] = tle_over(raw_x, tap_threshold) && tap_axis_select[tle_pkg::TAX_X]; // see R1 R11 R16
      over[1] = tle_over(raw_y, tap_threshold) && tap_axis_select[tle_pkg::TAX_Y]; // see R11
      over[0] = tle_over(raw_z, tap_threshold) && tap_axis_select[tle_pkg::TAX_Z]; // see R11
      above   = |over;
   end

   assign flags_read = reg_rd && (reg_addr == tle_pkg::ADDR_IRQ_FLAGS);

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tap_threshold     <= tle_pkg::RST_ZERO;
         tap_max_time      <= tle_pkg::RST_ZERO;
         tap_gap_time      <= tle_pkg::RST_ZERO;
         second_tap_window <= tle_pkg::RST_ZERO;
         tap_axis_select   <= tle_pkg::RST_ZERO;
         irq_mask          <= tle_pkg::RST_ZERO;
         irq_map           <= tle_pkg::RST_ZERO;
      end else if (reg_wr) begin
         case (reg_addr)
            tle_pkg::ADDR_TAP_THRESHOLD: tap_threshold     <= reg_wdata;
            tle_pkg::ADDR_TAP_MAX_TIME:  tap_max_time      <= reg_wdata;
            tle_pkg::ADDR_TAP_GAP_TIME:  tap_gap_time      <= reg_wdata;
            tle_pkg::ADDR_SECOND_WINDOW: second_tap_window <= reg_wdata;
            tle_pkg::ADDR_TAP_AXIS:      tap_axis_select   <= {4'h0, reg_wdata[3:0]};
            tle_pkg::ADDR_IRQ_MASK:      irq_mask          <= reg_wdata;
            tle_pkg::ADDR_IRQ_MAP:       irq_map           <= reg_wdata;
            default: ;
         endcase
      end
   end

   // registered read data, one cycle after the read strobe
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            tle_pkg::ADDR_TAP_THRESHOLD: reg_rdata <= tap_threshold;
            tle_pkg::ADDR_TAP_MAX_TIME:  reg_rdata <= tap_max_time;
            tle_pkg::ADDR_TAP_GAP_TIME:  reg_rdata <= tap_gap_time;
            tle_pkg::ADDR_SECOND_WINDOW: reg_rdata <= second_tap_window;
            tle_pkg::ADDR_TAP_AXIS:      reg_rdata <= tap_axis_select;
            tle_pkg::ADDR_MOTION_SOURCE: reg_rdata <= {4'h0, asleep, tap_axis_src}; // see R19
            tle_pkg::ADDR_IRQ_MASK:      reg_rdata <= irq_mask;
            tle_pkg::ADDR_IRQ_MAP:       reg_rdata <= irq_map;
            tle_pkg::ADDR_IRQ_FLAGS:     reg_rdata <= irq_flags;
            default:                     reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tap timer tick, fixed period of the internal sample clock
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else if (tick_cnt == tle_pkg::TAP_TICK_LAST) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b1; // see R25
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
         tick     <= 1'b0;
      end
   end

   // output rate: every 2^(15-rate_sel)th raw sample, every 512th for rate_sel below 7, capped at the raw rate
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dec_cnt <= 9'h000;
         odr_stb <= 1'b0;
      end else begin
         odr_stb <= 1'b0;
         if (sample_stb) begin
            dec_cnt <= dec_cnt + 9'h001;
            if (rate_sel >= 4'h0f || (dec_cnt & ((9'h001 << (4'h0f - rate_sel)) - 9'h001)) == 9'h000)
               odr_stb <= 1'b1; // see R15
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   tle_tap_fsm u_tap (
      .core_clk    (core_clk),
      .rstn        (rstn),
      .tick        (tick),
      .sample_stb  (sample_stb),
      .above       (above),
      .max_time    (tap_max_time),
      .gap_time    (tap_gap_time),
      .win_time    (second_tap_window),
      .veto_en     (tap_axis_select[tle_pkg::TAX_VETO]),
      .stap_en     (irq_mask[tle_pkg::IRQ_STAP]), // see R10
      .dtap_en     (irq_mask[tle_pkg::IRQ_DTAP]), // see R10
      .first_start (first_start),
      .stap_pulse  (stap_pulse),
      .dtap_pulse  (dtap_pulse)
   );

   // first axis over threshold, latched at tap start; never cleared
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         tap_axis_src <= 3'h0;
      else if (first_start)
         tap_axis_src <= over[2] ? 3'h4 : (over[1] ? 3'h2 : 3'h1); // see R14
   end

   ////////////////////////////////////////////////////////////////////////
   // link mode: alternate between seeking activity and inactivity
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         seek_act <= 1'b1;
      else if (!chain_en)
         seek_act <= 1'b1;
      else if (act_ok)
         seek_act <= 1'b0; // see R17
      else if (inact_ok)
         seek_act <= 1'b1;
   end

   assign act_ok   = act_evt && irq_mask[tle_pkg::IRQ_ACT] && (!chain_en || seek_act);
   assign inact_ok = inact_evt && irq_mask[tle_pkg::IRQ_INACT] && (!chain_en || !seek_act);

   // autosleep follows inactivity, but not while activity is still flagged
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         asleep <= 1'b0;
      else if (act_ok || !autosleep_en)
         asleep <= 1'b0;
      else if (inact_ok && !irq_flags[tle_pkg::IRQ_ACT])
         asleep <= 1'b1; // see R18 R19
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky event flags, watermark and overrun follow their levels; a set in the read cycle wins over the clear
   always_comb begin
      set_vec                       = 8'h00;
      set_vec[tle_pkg::IRQ_STAP]    = stap_pulse;
      set_vec[tle_pkg::IRQ_DTAP]    = dtap_pulse;
      set_vec[tle_pkg::IRQ_ACT]     = act_ok;
      set_vec[tle_pkg::IRQ_INACT]   = inact_ok;
      set_vec[tle_pkg::IRQ_FFALL]   = ffall_evt && irq_mask[tle_pkg::IRQ_FFALL];
      set_vec[tle_pkg::IRQ_DREADY]  = dready_set && !asleep; // see R20
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_flags <= 8'h00;
      end else begin
         irq_flags[7:2] <= (flags_read ? (irq_flags[7:2] & 6'h20) : irq_flags[7:2]) | set_vec[7:2]; // see R22 R18
         if (dready_clr && !set_vec[tle_pkg::IRQ_DREADY])
            irq_flags[tle_pkg::IRQ_DREADY] <= 1'b0;
         irq_flags[tle_pkg::IRQ_WMARK]   <= wmark_lvl;
         irq_flags[tle_pkg::IRQ_OVERRUN] <= ovr_lvl;
      end
   end

   // pin routing by map bit, ORed per pin
   assign live = irq_flags & irq_mask;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_pin_a <= 1'b0;
         irq_pin_b <= 1'b0;
      end else begin
         irq_pin_a <= |(live & ~irq_map); // see R23
         irq_pin_b <= |(live & irq_map);  // see R23
      end
   end
endmodule

// [testbench/tle_props.sv]
// assertions on the ports of the tap and link event logic
// assumes one core clock and the asynchronous active-low reset of tle_top
`timescale 1ns/1ns
module tle_props (
   input wire logic       core_clk,
   input wire logic       rstn,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       sample_stb,
   input wire logic       act_evt,
   input wire logic       inact_evt,
   input wire logic       autosleep_en,
   input wire logic       odr_stb,
   input wire logic       asleep,
   input wire logic       irq_pin_a,
   input wire logic       irq_pin_b
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   // quiet outputs after reset and register port answers
   AST_RESET_QUIET: assert property (
      !$past(rstn) |-> !irq_pin_a && !irq_pin_b && !asleep && !odr_stb)
      else $error("outputs not quiet after reset");
   AST_RDATA_STANDS: assert property (
      !$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   AST_UNMAPPED_ZERO: assert property (
      reg_rd && reg_addr < tle_pkg::ADDR_TAP_THRESHOLD |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_AXIS_HIGH_ZERO: assert property (
      reg_rd && reg_addr == tle_pkg::ADDR_TAP_AXIS |=> reg_rdata[7:4] == 4'h0)
      else $error("axis select upper bits not zero");
   AST_ASLEEP_STATUS: assert property (
      reg_rd && reg_addr == tle_pkg::ADDR_MOTION_SOURCE |=> reg_rdata[3] == $past(asleep))
      else $error("dozing bit differs from asleep");
   ////////////////////////////////////////
   // sleep and output strobe causes, a registered stage or two allowed
   AST_SLEEP_CAUSE: assert property (
      $rose(asleep) |-> $past(autosleep_en) && ($past(inact_evt) || $past(inact_evt, 2)))
      else $error("sleep entered without inactivity");
   AST_WAKE_CAUSE: assert property (
      $fell(asleep) |-> $past(act_evt) || $past(act_evt, 2))
      else $error("sleep left without activity");
   AST_ODR_FROM_SAMPLE: assert property (
      odr_stb |-> $past(sample_stb))
      else $error("output strobe without a sample");
   AST_ODR_SINGLE: assert property (
      odr_stb && !sample_stb |=> !odr_stb)
      else $error("output strobe longer than a cycle");
   // main scenarios reached
   COV_PIN_A: cover property ($rose(irq_pin_a));
   COV_PIN_B: cover property ($rose(irq_pin_b));
   COV_SLEEP: cover property ($rose(asleep));
endmodule

// [testbench/tle_host_model.sv]
// host processor model driving the byte register port
// assumes strobes are taken at the rising edge; drives on falling edges
`timescale 1ns/1ns
module tle_host_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one write; released lines show inverted data, never stale values
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
   endtask
   // one read, data taken once it has settled; reading flags clears events
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge core_clk);
      v = reg_rdata;
   endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the tap and link event logic
// assumes tle_top, tle_pkg and the host model; inputs change on falling edges
`timescale 1ns/1ns
module tb_top;
   logic        core_clk, rstn, reg_wr, reg_rd, sample_stb, chain_en, autosleep_en;
   logic        odr_stb, asleep, irq_pin_a, irq_pin_b, seen;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
   logic [12:0] raw_x, raw_y, raw_z;
   logic [2:0]  ev;
   int          miscompares, n_tests;
   localparam logic [12:0] BIG = 13'h0640; // magnitude 50 after the shift
   localparam logic [12:0] NEG = 13'h19c0; // negative of BIG
   localparam logic [12:0] LOW = 13'h061f; // one step under threshold 0x31
   // low-power and FIFO setup lie outside this block
   tle_top dut (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_stb(sample_stb), .raw_x(raw_x), .raw_y(raw_y),
      .raw_z(raw_z), .rate_sel(4'hf), .act_evt(ev[0]), .inact_evt(ev[1]), .ffall_evt(1'b0),
      .dready_set(ev[2]), .dready_clr(1'b0), .wmark_lvl(1'b0), .ovr_lvl(1'b0), .chain_en(chain_en),
      .autosleep_en(autosleep_en), .odr_stb(odr_stb), .asleep(asleep), .irq_pin_a(irq_pin_a),
      .irq_pin_b(irq_pin_b));
   tle_host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   ////////////////////////////////////////
   // 20 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, d);
      chk_byte(d, exp);
   endtask
   // one raw sample; lines inverted between strobes so nothing stale is seen
   task automatic samp(input logic [12:0] x, input logic [12:0] y, input logic [12:0] z);
      @(negedge core_clk);
      sample_stb = 1'b1;
      {raw_x, raw_y, raw_z} = {x, y, z};
      @(negedge core_clk);
      sample_stb = 1'b0;
      {raw_x, raw_y, raw_z} = ~{x, y, z};
      chk_bit(odr_stb, 1'b1);
      repeat (2) @(negedge core_clk);
   endtask
   task automatic tap(input logic [12:0] x);
      samp(x, 13'h0000, 13'h0000);
      samp(x, 13'h0000, 13'h0000);
      samp(13'h0000, 13'h0000, 13'h0000);
   endtask
   // bounded wait for a pin to rise
   task automatic wait_pin(input logic b);
      seen = 1'b0;
      for (int i = 0; i < 40 && !seen; i++) begin
         @(negedge core_clk);
         seen = ((b ? irq_pin_b : irq_pin_a) === 1'b1);
      end
   endtask
   task automatic pulse(input logic [2:0] v);
      @(negedge core_clk);
      ev = v;
      @(negedge core_clk);
      ev = 3'b000;
      repeat (3) @(negedge core_clk);
   endtask
   ////////////////////////////////////////
   task automatic t_regs();
      host.wr(tle_pkg::ADDR_MOTION_SOURCE, 8'hff);
      host.wr(tle_pkg::ADDR_IRQ_FLAGS, 8'hff);
      rdchk(tle_pkg::ADDR_MOTION_SOURCE, 8'h00);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h00);
      rdchk(8'h10, 8'h00);
      host.wr(tle_pkg::ADDR_TAP_AXIS, 8'hff);
      rdchk(tle_pkg::ADDR_TAP_AXIS, 8'h0f);
      host.wr(tle_pkg::ADDR_TAP_THRESHOLD, 8'h31); // above 3 g
      rdchk(tle_pkg::ADDR_TAP_THRESHOLD, 8'h31);
   endtask
   task automatic t_single();
      host.wr(tle_pkg::ADDR_TAP_AXIS, 8'h06);
      host.wr(tle_pkg::ADDR_IRQ_MASK, 8'h40);
      host.wr(tle_pkg::ADDR_TAP_MAX_TIME, 8'h02);
      samp(13'h0000, BIG, 13'h0000);
      samp(NEG, BIG, 13'h0000);
      samp(13'h0000, 13'h0000, 13'h0000);
      wait_pin(1'b0);
      chk_bit(seen, 1'b1);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h40);
      rdchk(tle_pkg::ADDR_MOTION_SOURCE, 8'h02);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h00);
      chk_bit(irq_pin_a, 1'b0);
   endtask
   task automatic t_axes();
      host.wr(tle_pkg::ADDR_TAP_AXIS, 8'h01);
      tap(BIG);
      wait_pin(1'b0);
      chk_bit(seen, 1'b0);
      host.wr(tle_pkg::ADDR_TAP_AXIS, 8'h04);
      tap(LOW);
      wait_pin(1'b0);
      chk_bit(seen, 1'b0);
      host.wr(tle_pkg::ADDR_IRQ_MAP, 8'h40);
      tap(NEG);
      wait_pin(1'b1);
      chk_bit(seen, 1'b1);
      chk_bit(irq_pin_a, 1'b0);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h40);
      host.wr(tle_pkg::ADDR_IRQ_MAP, 8'h00);
   endtask
   // both gap and window nonzero so the double detector runs
   task automatic t_double();
      host.wr(tle_pkg::ADDR_IRQ_MASK, 8'h60);
      host.wr(tle_pkg::ADDR_TAP_GAP_TIME, 8'h01);
      host.wr(tle_pkg::ADDR_SECOND_WINDOW, 8'h04);
      tap(BIG);
      // past a one-tick gap, well inside a four-tick window
      repeat (26000) @(negedge core_clk);
      samp(13'h0000, 13'h0000, 13'h0000); // opens window
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h00);
      tap(BIG);
      wait_pin(1'b0);
      chk_bit(seen, 1'b1);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h60);
   endtask
   task automatic t_veto();
      host.wr(tle_pkg::ADDR_TAP_AXIS, 8'h0c);
      host.wr(tle_pkg::ADDR_TAP_GAP_TIME, 8'h02);
      tap(BIG);
      tap(BIG);
      wait_pin(1'b0);
      chk_bit(seen, 1'b1);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h40);
   endtask
   task automatic t_sleep();
      host.wr(tle_pkg::ADDR_IRQ_MASK, 8'h18);
      autosleep_en = 1'b1;
      pulse(3'b001);
      pulse(3'b010);
      chk_bit(asleep, 1'b0);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h18);
      pulse(3'b010);
      chk_bit(asleep, 1'b1);
      rdchk(tle_pkg::ADDR_MOTION_SOURCE, 8'h0c);
      pulse(3'b100);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h08);
      chain_en = 1'b1;
      pulse(3'b010);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h00);
      pulse(3'b001);
      chk_bit(asleep, 1'b0);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h10);
      pulse(3'b001);
      rdchk(tle_pkg::ADDR_IRQ_FLAGS, 8'h00);
   endtask
   task automatic give_verdict();
      if (miscompares == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // main sequence after a two-cycle reset
   initial begin
      {rstn, ev, sample_stb, raw_x, raw_y, raw_z, chain_en, autosleep_en} = '0;
      miscompares = 0;
      n_tests = 0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      t_regs();
      t_single();
      t_axes();
      t_double();
      t_veto();
      t_sleep();
      give_verdict();
   end
   // watchdog: the double tap wait dominates at about 26000 cycles
   initial begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      give_verdict();
   end
endmodule
bind tle_top tle_props u_props (.core_clk(core_clk), .rstn(rstn), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .sample_stb(sample_stb), .act_evt(act_evt), .inact_evt(inact_evt),
   .autosleep_en(autosleep_en), .odr_stb(odr_stb), .asleep(asleep), .irq_pin_a(irq_pin_a),
   .irq_pin_b(irq_pin_b));
